/* File: inc/wksd_defines.svh */
// Contract
// RL1 - SID zero: no modem transmits in interval
// RL2 - SID 3FFF: interval open to every modem
// RL3 - Multicast SIDs only in request/data elements
// RL4 - Multicast N: start at 1+kN, fit N
// RL5 - SID 3FF1: start anywhere, one slot
// RL6 - SID 3FFD: starts every thirteenth slot
// RL7 - 3Exx: low byte bit k permits priority k
// RL8 - Scheduler may set any priority bit mix
// RL9 - Other SIDs unicast; act only on own
// RL10 - All-modem frames use well-known multicast address
// RL11 - Reserved multicast range stays inside cable domain
// RL12 - Addresses compared in 802.3 bit order
// RL13 - Only data PID packets reach the MAC
// RL14 - One exclusive class per supplied identifier
`ifndef WKSD_DEFINES_SVH
`define WKSD_DEFINES_SVH
`define WKSD_SID_W       14
`define WKSD_LEN_W       8
`define WKSD_IUC_W       4
`define WKSD_PID_W       13
`define WKSD_SID_NONE    14'h0000
`define WKSD_SID_ALL     14'h3FFF
`define WKSD_SID_MC_HI   10'h3FF
`define WKSD_SID_PRIO_HI 6'h3E
`define WKSD_IUC_REQ     4'h1
`define WKSD_IUC_REQDATA 4'h2
`define WKSD_MAC_ALL     48'h01E02F000001
`define WKSD_MAC_RSV_HI  40'h01E02F0000
`define WKSD_MAC_RSV_LO  8'h03
`define WKSD_MAC_RSV_TOP 8'h0F
`define WKSD_PID_DATA    13'h1FFE
`define WKSD_SLOT_DIV    8'h10
`endif

/* File: inc/wksd_pkg.sv */
package wksd_pkg;
  typedef enum logic [5:0]
  {
    WKSD_CLS_NONE   = 6'b000001,
    WKSD_CLS_BCAST  = 6'b000010,
    WKSD_CLS_MCAST  = 6'b000100,
    WKSD_CLS_PRIO   = 6'b001000,
    WKSD_CLS_UCAST  = 6'b010000,
    WKSD_CLS_NOMATCH = 6'b100000
  } wksd_class_t;
  typedef enum logic [1:0]
  {
    WKSD_ST_IDLE = 2'b01,
    WKSD_ST_OPEN = 2'b10
  } wksd_state_t;
endpackage

/* File: inc/wksd_if.sv */
`timescale 1ns/10ps
`include "wksd_defines.svh"
interface wksd_if;
  logic                    ie_valid;
  logic [`WKSD_SID_W-1:0]  ie_sid;
  logic [`WKSD_IUC_W-1:0]  ie_iuc;
  logic [`WKSD_LEN_W-1:0]  ie_len;
  logic                    slot_tick;
  logic                    frame_valid;
  logic [47:0]             frame_da;
  logic                    ts_valid;
  logic [`WKSD_PID_W-1:0]  ts_pid;
  modport modem (input ie_valid, ie_sid, ie_iuc, ie_len, slot_tick,
                 input frame_valid, frame_da, ts_valid, ts_pid);
  modport sched (output ie_valid, ie_sid, ie_iuc, ie_len, slot_tick,
                 output frame_valid, frame_da, ts_valid, ts_pid);
endinterface

/* File: hw/wksd_sched.sv */
`timescale 1ns/10ps
`include "wksd_defines.svh"
module wksd_sched
(
  input  wire logic                   clock,
  input  wire logic                   rst,
  wksd_if.sched                       link,
  input  wire logic                   req_valid,
  input  wire logic [`WKSD_SID_W-1:0] req_sid,
  input  wire logic [`WKSD_IUC_W-1:0] req_iuc,
  input  wire logic [`WKSD_LEN_W-1:0] req_len,
  input  wire logic                   map_valid,
  input  wire logic                   map_to_all,
  input  wire logic [47:0]            map_da,
  input  wire logic                   pkt_valid,
  output logic                        req_refused
);
  // ****************************************************************
  // Element checks and slot divider
  // ****************************************************************
  logic [7:0] div;
  wire        div_wrap = (div == `WKSD_SLOT_DIV - 8'h01);
  wire        is_mcast = (req_sid[13:4] == `WKSD_SID_MC_HI) &&
                         (req_sid[3:0] != 4'hF) && (req_sid[3:0] != 4'h0);
  // Any mix of priority bits passes untouched.
  wire        bad_mc   = is_mcast && (req_iuc != `WKSD_IUC_REQDATA); // RL3 RL8
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      div              <= 8'h00;
      link.slot_tick   <= 1'b0;
      link.ie_valid    <= 1'b0;
      link.ie_sid      <= `WKSD_SID_NONE;
      link.ie_iuc      <= 4'h0;
      link.ie_len      <= 8'h00;
      link.frame_valid <= 1'b0;
      link.frame_da    <= 48'h000000000000;
      link.ts_valid    <= 1'b0;
      link.ts_pid      <= 13'h0000;
      req_refused      <= 1'b0;
    end
    else
    begin
      div              <= div_wrap ? 8'h00 : div + 8'h01;
      link.slot_tick   <= div_wrap;
      link.ie_valid    <= req_valid && !bad_mc; // RL9
      link.ie_sid      <= req_sid;
      link.ie_iuc      <= req_iuc;
      link.ie_len      <= req_len;
      req_refused      <= req_valid && bad_mc; // RL3
      link.frame_valid <= map_valid;
      link.frame_da    <= map_to_all ? `WKSD_MAC_ALL : map_da; // RL10
      link.ts_valid    <= pkt_valid;
      link.ts_pid      <= `WKSD_PID_DATA; // RL13
    end
  end
endmodule

/* File: hw/wksd_modem.sv */
`timescale 1ns/10ps
`include "wksd_defines.svh"
module wksd_modem
#(
  parameter int N_SID = 4
)
(
  input  wire logic                         clock,
  input  wire logic                         rst,
  wksd_if.modem                             link,
  input  wire logic [N_SID*`WKSD_SID_W-1:0] own_sid,
  input  wire logic [2:0]                   own_prio,
  output wksd_pkg::wksd_class_t             sid_class,
  output logic      [3:0]                   mc_spacing,
  output logic                              tx_start_ok,
  output logic      [`WKSD_LEN_W-1:0]       tx_max_slots,
  output logic                              frame_accept,
  output logic                              frame_local_only,
  output logic                              ts_pass
);
  // ****************************************************************
  // Identifier decode
  // ****************************************************************
  logic [N_SID-1:0] own_hit;

  genvar g;
  generate
    for (g = 0; g < N_SID; g = g + 1)
    begin : g_own
      assign own_hit[g] = (own_sid[g*`WKSD_SID_W +: `WKSD_SID_W] == link.ie_sid);
    end
  endgenerate

  wire [3:0] sid_digit = link.ie_sid[3:0];
  wire       hit_none  = (link.ie_sid == `WKSD_SID_NONE);
  wire       hit_all   = (link.ie_sid == `WKSD_SID_ALL);
  wire       hit_mc    = (link.ie_sid[13:4] == `WKSD_SID_MC_HI) &&
                         (sid_digit != 4'h0) && (sid_digit != 4'hF);
  wire       hit_prio  = (link.ie_sid[13:8] == `WKSD_SID_PRIO_HI);
  wire       mc_ok     = (link.ie_iuc == `WKSD_IUC_REQDATA); // RL3
  wire       prio_ok   = link.ie_sid[own_prio]; // RL7
  wire       hit_own   = |own_hit; // RL9

  // The class choice is a strict priority chain, so exactly one bit of
  // the one-hot code can ever be set.
  wksd_pkg::wksd_class_t cls_now;
  assign cls_now = hit_none ? wksd_pkg::WKSD_CLS_NONE :              // RL1
                   hit_all  ? wksd_pkg::WKSD_CLS_BCAST :             // RL2
                   (hit_mc && mc_ok) ? wksd_pkg::WKSD_CLS_MCAST :    // RL3
                   hit_mc   ? wksd_pkg::WKSD_CLS_NOMATCH :
                   (hit_prio && prio_ok) ? wksd_pkg::WKSD_CLS_PRIO :  // RL7
                   hit_prio ? wksd_pkg::WKSD_CLS_NOMATCH :
                   hit_own  ? wksd_pkg::WKSD_CLS_UCAST :             // RL9
                   wksd_pkg::WKSD_CLS_NOMATCH;                       // RL14

  // A digit of one gives a step of one slot, which covers the
  // single-slot identifier with no separate case.
  wire [3:0] spacing_now = (hit_mc && mc_ok) ? sid_digit : 4'h0; // RL4 RL5 RL6

  // Intervals that nobody may use never open the transmit window.
  wire usable_now = (cls_now != wksd_pkg::WKSD_CLS_NONE) &&
                    (cls_now != wksd_pkg::WKSD_CLS_NOMATCH); // RL1

  // ****************************************************************
  // Interval tracking
  // ****************************************************************
  wksd_pkg::wksd_state_t     state;
  wksd_pkg::wksd_state_t     next_state;
  logic [`WKSD_LEN_W-1:0]    remain;
  logic [3:0]                phase;
  logic [3:0]                step;
  logic                      is_mc;
  logic                      first_slot;

  wire open_new = link.ie_valid && usable_now && (link.ie_len != 8'h00);
  wire last     = (remain == 8'h01);
  wire at_start = (phase == 4'h0);
  wire phase_wr = is_mc && (phase == step - 4'h1);

  // Unicast, broadcast and priority grants start only in the first slot;
  // multicast grants start on every step boundary.
  wire start_now = link.slot_tick && at_start &&
                   (is_mc || (remain != 8'h00 && first_slot)); // RL4 RL6

  // Burst limit: one step for multicast, the rest of the grant otherwise.
  wire [`WKSD_LEN_W-1:0] limit_now = is_mc ? {4'h0, step} : remain; // RL4 RL5

  always_comb
  begin
    next_state = state;
    unique case (state)
      wksd_pkg::WKSD_ST_IDLE:
      begin
        if (open_new)
        begin
          next_state = wksd_pkg::WKSD_ST_OPEN;
        end
      end
      wksd_pkg::WKSD_ST_OPEN:
      begin
        if (link.slot_tick && last && !open_new)
        begin
          next_state = wksd_pkg::WKSD_ST_IDLE;
        end
      end
      default:
      begin
        next_state = wksd_pkg::WKSD_ST_IDLE;
      end
    endcase
  end

  wire in_open = (state == wksd_pkg::WKSD_ST_OPEN);

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state <= wksd_pkg::WKSD_ST_IDLE;
    end
    else
    begin
      state <= next_state;
    end
  end

  // A fresh usable element of nonzero length replaces the interval in flight; the scheduler is
  // trusted not to overlap grants, so the newest one wins.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      remain     <= 8'h00;
      phase      <= 4'h0;
      step       <= 4'h0;
      is_mc      <= 1'b0;
      first_slot <= 1'b0;
    end
    else if (open_new)
    begin
      remain     <= link.ie_len;
      phase      <= 4'h0;
      step       <= spacing_now;
      is_mc      <= (cls_now == wksd_pkg::WKSD_CLS_MCAST);
      first_slot <= 1'b1;
    end
    else if (in_open && link.slot_tick)
    begin
      remain     <= remain - 8'h01;
      phase      <= phase_wr ? 4'h0 : (is_mc ? phase + 4'h1 : 4'h0); // RL4
      first_slot <= 1'b0;
    end
  end

  // ****************************************************************
  // Registered outputs
  // ****************************************************************
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      sid_class    <= wksd_pkg::WKSD_CLS_NOMATCH;
      mc_spacing   <= 4'h0;
      tx_start_ok  <= 1'b0;
      tx_max_slots <= 8'h00;
    end
    else
    begin
      if (link.ie_valid)
      begin
        sid_class  <= cls_now; // RL14
        mc_spacing <= spacing_now;
      end
      tx_start_ok  <= in_open && !open_new && start_now; // RL1 RL2
      tx_max_slots <= (in_open && !open_new && start_now) ? limit_now : 8'h00;
    end
  end

  // ****************************************************************
  // Frame and packet filters
  // ****************************************************************
  // Addresses arrive in canonical octet order with the group bit in bit
  // 40, the wire's first bit; matching whole octets keeps that order.
  wire da_all = (link.frame_da == `WKSD_MAC_ALL); // RL10 RL12
  wire da_rsv = (link.frame_da[47:8] == `WKSD_MAC_RSV_HI) &&
                (link.frame_da[7:0] >= `WKSD_MAC_RSV_LO) &&
                (link.frame_da[7:0] <= `WKSD_MAC_RSV_TOP); // RL11 RL12

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      frame_accept     <= 1'b0;
      frame_local_only <= 1'b0;
      ts_pass          <= 1'b0;
    end
    else
    begin
      frame_accept     <= link.frame_valid && da_all; // RL10
      frame_local_only <= link.frame_valid && da_rsv; // RL11
      ts_pass          <= link.ts_valid && (link.ts_pid == `WKSD_PID_DATA); // RL13
    end
  end
endmodule

/* File: dv/wksd_props.sv */
`timescale 1ns/10ps
module wksd_props
(
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        req_valid,
  input wire logic [13:0] req_sid,
  input wire logic [3:0]  req_iuc,
  input wire logic        req_refused,
  input wire logic        map_valid,
  input wire logic        map_to_all,
  input wire logic [47:0] map_da,
  input wire logic        pkt_valid,
  input wire logic        ie_valid,
  input wire logic [13:0] ie_sid,
  input wire logic [3:0]  ie_iuc,
  input wire logic        slot_tick,
  input wire logic        frame_valid,
  input wire logic [47:0] frame_da,
  input wire logic        ts_valid,
  input wire logic [12:0] ts_pid
);
  // ********************
  // Link checks
  // ********************
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire mc_bad = req_sid > 14'h3FF0 && req_sid < 14'h3FFF && req_iuc != 4'h2;
  property p_refuse; req_valid && mc_bad |=> req_refused && !ie_valid; endproperty
  a_refuse: assert property (p_refuse) else $error("not refused");
  property p_fwd;
    req_valid && !mc_bad |=> ie_valid && ie_sid == $past(req_sid) && ie_iuc == $past(req_iuc);
  endproperty
  a_fwd: assert property (p_fwd) else $error("element lost");
  property p_mc_iuc;
    ie_valid && ie_sid > 14'h3FF0 && ie_sid < 14'h3FFF |-> ie_iuc == 4'h2;
  endproperty
  a_mc_iuc: assert property (p_mc_iuc) else $error("bad code");
  property p_cause; ie_valid |-> $past(req_valid); endproperty
  a_cause: assert property (p_cause) else $error("stray element");
  property p_all;
    map_valid && map_to_all |=> frame_valid && frame_da == 48'h01E02F000001;
  endproperty
  a_all: assert property (p_all) else $error("bad group address");
  property p_da; map_valid && !map_to_all |=> frame_valid && frame_da == $past(map_da); endproperty
  a_da: assert property (p_da) else $error("address altered");
  property p_pid; pkt_valid |=> ts_valid && ts_pid == 13'h1FFE; endproperty
  a_pid: assert property (p_pid) else $error("bad pid");
  // Ticks come every sixteen clocks, so no two may be closer.
  property p_tick; slot_tick |=> !slot_tick [*8] ##1 !slot_tick [*7] ##1 slot_tick; endproperty
  a_tick: assert property (p_tick) else $error("tick spacing");
  c_ref: cover property (req_valid && mc_bad);
  c_all: cover property (map_valid && map_to_all);
  c_mc: cover property (ie_valid && ie_sid == 14'h3FFD);
endmodule

/* File: dv/testbench.sv */
`timescale 1ns/10ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin bad_count++; \
$display("Error t=%0t got %h exp %h", $time, a, b); end end
module testbench;
  logic                  clock = 1'b0, rst = 1'b1, req_valid = 1'b0, map_valid = 1'b0;
  logic                  map_to_all = 1'b0, pkt_valid = 1'b0;
  logic [13:0]           req_sid = 14'h0000, s;
  logic [3:0]            req_iuc = 4'h0, mc_spacing, last_sp = 4'h0;
  logic [7:0]            req_len = 8'h00, tx_max_slots;
  logic [47:0]           map_da = 48'h0;
  logic [55:0]           own_sid = {14'h1000, 14'h2ABC, 14'h0456, 14'h0123};
  logic [2:0]            own_prio = 3'h7;
  logic                  req_refused, tx_start_ok, frame_accept, frame_local_only, ts_pass;
  logic [31:0]           v;
  wksd_pkg::wksd_class_t sid_class, last_cls;
  int                    bad_count, total_checks, cycles, seed = 81429;
  wksd_if link ();
  wksd_sched u_wksd_sched (.clock(clock), .rst(rst), .link(link), .req_valid(req_valid),
    .req_sid(req_sid), .req_iuc(req_iuc), .req_len(req_len), .map_valid(map_valid),
    .map_to_all(map_to_all), .map_da(map_da), .pkt_valid(pkt_valid), .req_refused(req_refused));
  wksd_modem u_wksd_modem (.clock(clock), .rst(rst), .link(link), .own_sid(own_sid),
    .own_prio(own_prio), .sid_class(sid_class), .mc_spacing(mc_spacing),
    .tx_start_ok(tx_start_ok), .tx_max_slots(tx_max_slots), .frame_accept(frame_accept),
    .frame_local_only(frame_local_only), .ts_pass(ts_pass));
  wksd_props u_wksd_props (.clock(clock), .rst(rst), .req_valid(req_valid), .req_sid(req_sid),
    .req_iuc(req_iuc), .req_refused(req_refused), .map_valid(map_valid), .map_to_all(map_to_all),
    .map_da(map_da), .pkt_valid(pkt_valid), .ie_valid(link.ie_valid), .ie_sid(link.ie_sid),
    .ie_iuc(link.ie_iuc), .slot_tick(link.slot_tick), .frame_valid(link.frame_valid),
    .frame_da(link.frame_da), .ts_valid(link.ts_valid), .ts_pid(link.ts_pid));
  always #5 clock = ~clock;
  // ********************
  // Expectations and drivers
  // ********************
  function automatic wksd_pkg::wksd_class_t exp_cls(logic [13:0] s, logic [3:0] c);
    if (s == 14'h0000) return wksd_pkg::WKSD_CLS_NONE;
    if (s == 14'h3FFF) return wksd_pkg::WKSD_CLS_BCAST;
    if (s > 14'h3FF0 && c == 4'h2) return wksd_pkg::WKSD_CLS_MCAST;
    if (s[13:8] == 6'h3E && s[own_prio]) return wksd_pkg::WKSD_CLS_PRIO;
    for (int g = 0; g < 4; g++)
      if (own_sid[g*14+:14] == s) return wksd_pkg::WKSD_CLS_UCAST;
    return wksd_pkg::WKSD_CLS_NOMATCH;
  endfunction
  task automatic run_ie(logic [13:0] s, logic [3:0] c, logic [7:0] l);
    logic       rf;
    logic [7:0] n;
    int         cnt;
    @(posedge clock);
    rf = s > 14'h3FF0 && s < 14'h3FFF && c != 4'h2;
    if (!rf)
    begin
      last_cls = exp_cls(s, c);
      last_sp = last_cls == wksd_pkg::WKSD_CLS_MCAST ? s[3:0] : 4'h0;
    end
    n = last_sp == 4'h0 ? l : {4'h0, last_sp};
    cnt = 0;
    req_valid <= 1'b1;
    req_sid <= s;
    req_iuc <= c;
    req_len <= l;
    @(posedge clock);
    req_valid <= 1'b0;
    #1 `CHK(req_refused, rf)
    @(posedge clock);
    #1 `CHK(sid_class, last_cls)
    `CHK(mc_spacing, last_sp)
    // The window outlasts the interval, so no grant can leak into the next element.
    repeat (16 * l + 40)
    begin
      @(posedge clock);
      #1 if (tx_start_ok === 1'b1)
      begin
        cnt++;
        `CHK(tx_max_slots, n)
      end
    end
    `CHK(cnt, rf || l == 8'h0 || !(|last_cls[4:1]) ? 0 : (l + n - 1) / n)
  endtask
  task automatic run_fr(logic all, logic [47:0] d, logic p);
    logic [47:0] e;
    e = all ? 48'h01E02F000001 : d;
    @(posedge clock);
    map_valid <= 1'b1;
    map_to_all <= all;
    map_da <= d;
    pkt_valid <= p;
    @(posedge clock);
    map_valid <= 1'b0;
    pkt_valid <= 1'b0;
    @(posedge clock);
    #1 `CHK(frame_accept, e == 48'h01E02F000001)
    `CHK(frame_local_only, e >= 48'h01E02F000003 && e <= 48'h01E02F00000F)
    `CHK(ts_pass, p)
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // The longest run is under 30000 cycles.
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      bad_count++;
      print_verdict();
    end
  end
  initial
  begin
    last_cls = wksd_pkg::WKSD_CLS_NOMATCH;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    #1 `CHK(sid_class, last_cls)
    run_ie(14'h3FF1, 4'h2, 8'h05);
    run_ie(14'h3FFD, 4'h2, 8'h1B);
    run_ie(14'h3FFE, 4'h1, 8'h04);
    run_ie(14'h3E7F, 4'h1, 8'h02);
    run_fr(1'b0, 48'h01E02F00000F, 1'b1);
    run_fr(1'b0, 48'h01E02F000010, 1'b0);
    for (int t = 0; t < 100; t++)
    begin
      v = $random(seed);
      @(posedge clock);
      own_prio <= v[30:28];
      s = v[2:0] == 3'h0 ? 14'h0000 : v[2:0] == 3'h1 ? 14'h3FFF :
          v[2:1] == 2'h1 ? {10'h3FF, v[7:4]} : v[2:0] == 3'h4 ? {6'h3E, v[11:4]} :
          v[2:0] == 3'h5 ? own_sid[v[5:4]*14+:14] : v[17:4];
      run_ie(s, v[3] ? 4'h2 : v[15:12], {4'h0, v[27:24]});
      run_fr(v[23], v[20] ? {44'h01E02F00000, v[27:24]} : {v, v[15:0]}, v[21]);
      $display("test %0d done", t);
    end
    print_verdict();
  end
endmodule
